//--- src/fskm_defs.svh
// Constants of the FSK modem core: rates, tones, register map, fields, reset values
`ifndef FSKM_DEFS_SVH
`define FSKM_DEFS_SVH

// Master clock and derived rates
`define FSKM_CLK_HZ 100000000
`define FSKM_STEPS_PER_CYCLE 16
`define FSKM_DIV(f) (`FSKM_CLK_HZ / (`FSKM_STEPS_PER_CYCLE * (f)))
`define FSKM_TICK_HZ 1000
`define FSKM_TICK_DIV (`FSKM_CLK_HZ / `FSKM_TICK_HZ)

// Standard tone frequencies in Hz
`define FSKM_F_ORIG_MARK 1270
`define FSKM_F_ORIG_SPACE 1070
`define FSKM_F_ANS_MARK 2225
`define FSKM_F_ANS_SPACE 2025

// Register word addresses
`define FSKM_ADDR_STATUS 4'h0
`define FSKM_ADDR_MASK 4'h1
`define FSKM_ADDR_THRESH 4'h2
`define FSKM_ADDR_DELAY 4'h3
`define FSKM_ADDR_STATE 4'h4

// Status and mask bit positions
`define FSKM_EV_CARRIER_ON 0
`define FSKM_EV_CARRIER_OFF 1
`define FSKM_EV_RX_EDGE 2
`define FSKM_EV_W 3

// Reset values and fixed codes
`define FSKM_THRESH_RST 8'h40
`define FSKM_DELAY_RST 8'h0A
`define FSKM_MASK_RST 3'h0
`define FSKM_DAC_MID 8'h80

`endif

//--- src/fskm_pkg.sv
// Types shared by the FSK modem core
package fskm_pkg;

  // Operating modes of the control logic
  typedef enum logic [1:0] {
    FSKM_PWRDN = 2'b00,
    FSKM_ORIG = 2'b01,
    FSKM_ANS = 2'b10,
    FSKM_LOOP = 2'b11
  } fskm_mode_t;

  // Whole state of the core
  typedef struct packed {
    fskm_mode_t mode;
    logic [3:0] phase;
    logic [16:0] tick_cnt;
    logic tick_ms;
    logic [7:0] cd_cnt;
    logic cd_found;
    logic rx_bit;
    logic [2:0] status;
    logic [2:0] mask;
    logic [7:0] thresh;
    logic [7:0] delay;
    logic [7:0] rdata;
    logic [7:0] dac;
    logic drv_en;
  } fskm_state_t;

endpackage

//--- src/fskm_sine_rom.sv
// Sixteen-entry sine lookup with registered read data
`timescale 1ns/1ps
module fskm_sine_rom import fskm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Lookup
  input wire logic [3:0] addr,
  output logic [7:0] data
);

  typedef struct packed {
    logic [7:0] data;
  } fskm_rom_state_t;

  fskm_rom_state_t st_reg;
  fskm_rom_state_t st_next;

  // Staircase sine table, midscale offset
  always_comb begin
    st_next = st_reg;
    case (addr)
      4'h0: st_next.data = 8'h80;
      4'h1: st_next.data = 8'hB0;
      4'h2: st_next.data = 8'hDA;
      4'h3: st_next.data = 8'hF5;
      4'h4: st_next.data = 8'hFF;
      4'h5: st_next.data = 8'hF5;
      4'h6: st_next.data = 8'hDA;
      4'h7: st_next.data = 8'hB0;
      4'h8: st_next.data = 8'h80;
      4'h9: st_next.data = 8'h4F;
      4'hA: st_next.data = 8'h25;
      4'hB: st_next.data = 8'h0A;
      4'hC: st_next.data = 8'h01;
      4'hD: st_next.data = 8'h0A;
      4'hE: st_next.data = 8'h25;
      4'hF: st_next.data = 8'h4F;
      default: st_next.data = 8'h80;
    endcase
  end

  // Output register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data = st_reg.data;

endmodule // fskm_sine_rom

//--- src/fskm_tone_div.sv
// Programmable tone divider, divisor taken only at terminal count
`timescale 1ns/1ps
module fskm_tone_div import fskm_pkg::*; #(
  parameter int DIV_W = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  // Step enable at sixteen times the tone
  output logic tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] div;
    logic tick;
  } fskm_div_state_t;

  fskm_div_state_t st_reg;
  fskm_div_state_t st_next;

  // Count down; reload with the divisor seen at terminal count
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (run) begin
      if (st_reg.cnt == '0) begin
        st_next.tick = 1'b1;
        st_next.div = divisor;
        st_next.cnt = divisor - DIV_W'(1);
      end else begin
        st_next.cnt = st_reg.cnt - DIV_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  // Reload uses the divisor present at terminal count
  a_div_reload: assert property (@(posedge clk) disable iff (rst)
    (run && st_reg.cnt == '0) |=> (st_reg.div == $past(divisor) && st_reg.cnt == $past(divisor) - DIV_W'(1)))
    else $error("divider reload wrong");

  // Tick only after terminal count
  a_div_tick: assert property (@(posedge clk) disable iff (rst)
    tick |-> ($past(st_reg.cnt) == '0 && $past(run)))
    else $error("tick without terminal count");

endmodule // fskm_tone_div

//--- src/fskm_core.sv
// FSK modem digital core: tone synthesizer, mode control, carrier qualify, registers
//
// Operation
// - Transmit bit level steers tone, no bit clock
// - All timing derived from one master clock
// - Transmit bit and mode pick divider divisor
// - Divider ticks at sixteen times tone frequency
// - Tick advances four-bit phase counter, sixteen slots
// - Sine table maps phase to DAC code
// - Phase count kept across frequency changes
// - Mode pins select originate, answer, loopback
// - Squelch input silences line driver output
// - Loopback plus squelch together means power-down
// - Receive passband follows selected mode
// - Carrier found low after programmable qualify delay
// - Receive bit from mark versus space energy
// - Control sequences modes, divider supplies clocks
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "fskm_defs.svh"
module fskm_core import fskm_pkg::*; #(
  parameter int DIV_W = 13,
  parameter logic [DIV_W-1:0] DIV_ORIG_MARK = DIV_W'(`FSKM_DIV(`FSKM_F_ORIG_MARK)),
  parameter logic [DIV_W-1:0] DIV_ORIG_SPACE = DIV_W'(`FSKM_DIV(`FSKM_F_ORIG_SPACE)),
  parameter logic [DIV_W-1:0] DIV_ANS_MARK = DIV_W'(`FSKM_DIV(`FSKM_F_ANS_MARK)),
  parameter logic [DIV_W-1:0] DIV_ANS_SPACE = DIV_W'(`FSKM_DIV(`FSKM_F_ANS_SPACE)),
  parameter logic [16:0] TICK_DIV = 17'(`FSKM_TICK_DIV)
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Host mode and data pins
  input wire logic TXD,
  input wire logic ORIG_ANS,
  input wire logic LOOPBACK_SEL,
  input wire logic TX_SQUELCH,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Receive analog measurements
  input wire logic [7:0] RX_LEVEL,
  input wire logic [7:0] RX_MARK_ENERGY,
  input wire logic [7:0] RX_SPACE_ENERGY,
  // Transmit side
  output logic [7:0] DAC_CODE,
  output logic TX_DRIVER_EN,
  // Analog control
  output logic RX_BAND_HIGH,
  output logic LOOPBACK_EN,
  output logic POWER_DOWN,
  // Receive results and interrupt
  output logic CARRIER_FOUND_N,
  output logic RX_DATA,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  fskm_state_t st_reg;
  fskm_state_t st_next;
  logic [DIV_W-1:0] divisor;
  logic run;
  logic tone_tick;
  logic [7:0] rom_data;
  logic above;
  logic rx_dec;
  logic [2:0] events;
  logic tx_orig;

  ////////////////////////////////////////////////////////////////////////////
  // Tone synthesizer

  // Transmit band: answer end sends high tones
  assign tx_orig = ORIG_ANS;

  // Divisor from transmit level and mode, sampled with no bit clock
  always_comb begin
    if (tx_orig) begin
      divisor = TXD ? DIV_ORIG_MARK : DIV_ORIG_SPACE;
    end else begin
      divisor = TXD ? DIV_ANS_MARK : DIV_ANS_SPACE;
    end
  end

  // Synthesizer halted only in power-down
  assign run = (st_reg.mode != FSKM_PWRDN);

  // Tone step divider
  fskm_tone_div #(
    .DIV_W(DIV_W)
  ) u_div (
    .clk(CORE_CLK),
    .rst(RST),
    .run(run),
    .divisor(divisor),
    .tick(tone_tick)
  );

  // Phase to amplitude lookup
  fskm_sine_rom u_rom (
    .clk(CORE_CLK),
    .rst(RST),
    .addr(st_reg.phase),
    .data(rom_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive decisions and events

  // Level compare and energy compare
  assign above = (RX_LEVEL > st_reg.thresh);
  assign rx_dec = (RX_MARK_ENERGY >= RX_SPACE_ENERGY);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Mode control, phase, timers, registers
  always_comb begin
    st_next = st_reg;

    // Mode selection from host pins
    if (LOOPBACK_SEL && TX_SQUELCH) begin
      st_next.mode = FSKM_PWRDN;
    end else if (LOOPBACK_SEL) begin
      st_next.mode = FSKM_LOOP;
    end else if (ORIG_ANS) begin
      st_next.mode = FSKM_ORIG;
    end else begin
      st_next.mode = FSKM_ANS;
    end

    // Phase steps only on divider tick
    if (tone_tick) begin
      st_next.phase = st_reg.phase + 4'h1;
    end

    // Millisecond enable for the carrier delay
    st_next.tick_ms = 1'b0;
    if (st_reg.tick_cnt == '0) begin
      st_next.tick_cnt = TICK_DIV - 17'h00001;
      st_next.tick_ms = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt - 17'h00001;
    end

    // Carrier qualification
    if (!above || st_reg.mode == FSKM_PWRDN) begin
      st_next.cd_cnt = '0;
      st_next.cd_found = 1'b0;
    end else if (st_reg.cd_cnt >= st_reg.delay) begin
      st_next.cd_found = 1'b1;
    end else if (st_reg.tick_ms) begin
      st_next.cd_cnt = st_reg.cd_cnt + 8'h01;
    end

    // Receive bit, held while powered down
    if (st_reg.mode != FSKM_PWRDN) begin
      st_next.rx_bit = rx_dec;
    end

    // Transmit output: silent while squelched or powered down
    if (TX_SQUELCH || st_reg.mode == FSKM_PWRDN) begin
      st_next.dac = `FSKM_DAC_MID;
      st_next.drv_en = 1'b0;
    end else begin
      st_next.dac = rom_data;
      st_next.drv_en = 1'b1;
    end

    // Register writes
    if (WR) begin
      case (ADDR)
        `FSKM_ADDR_MASK: st_next.mask = WDATA[`FSKM_EV_W-1:0];
        `FSKM_ADDR_THRESH: st_next.thresh = WDATA;
        `FSKM_ADDR_DELAY: st_next.delay = WDATA;
        default: st_next.mask = st_reg.mask;
      endcase
    end

    // Register reads, data valid the following cycle only
    st_next.rdata = '0;
    if (RD) begin
      case (ADDR)
        `FSKM_ADDR_STATUS: st_next.rdata = {5'h00, st_reg.status};
        `FSKM_ADDR_MASK: st_next.rdata = {5'h00, st_reg.mask};
        `FSKM_ADDR_THRESH: st_next.rdata = st_reg.thresh;
        `FSKM_ADDR_DELAY: st_next.rdata = st_reg.delay;
        `FSKM_ADDR_STATE: st_next.rdata = {st_reg.phase, st_reg.rx_bit, st_reg.cd_found, st_reg.mode};
        default: st_next.rdata = '0;
      endcase
    end

    // Event pulses, taken here so no loop runs through st_next
    events = '0;
    events[`FSKM_EV_CARRIER_ON] = st_next.cd_found & ~st_reg.cd_found;
    events[`FSKM_EV_CARRIER_OFF] = ~st_next.cd_found & st_reg.cd_found;
    events[`FSKM_EV_RX_EDGE] = st_next.rx_bit ^ st_reg.rx_bit;

    // Sticky status: read clears, new event wins
    if (RD && ADDR == `FSKM_ADDR_STATUS) begin
      st_next.status = events;
    end else begin
      st_next.status = st_reg.status | events;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Constant reset values only
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.mode <= FSKM_PWRDN;
      st_reg.mask <= `FSKM_MASK_RST;
      st_reg.thresh <= `FSKM_THRESH_RST;
      st_reg.delay <= `FSKM_DELAY_RST;
      st_reg.dac <= `FSKM_DAC_MID;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Data from flip-flops, analog controls decoded from mode
  assign RDATA = st_reg.rdata;
  assign DAC_CODE = st_reg.dac;
  assign TX_DRIVER_EN = st_reg.drv_en;
  assign CARRIER_FOUND_N = ~st_reg.cd_found;
  assign RX_DATA = st_reg.rx_bit;
  assign POWER_DOWN = (st_reg.mode == FSKM_PWRDN);
  assign LOOPBACK_EN = (st_reg.mode == FSKM_LOOP);
  // Receive the far end's band; in loopback hear our own band
  assign RX_BAND_HIGH = (st_reg.mode == FSKM_ORIG) || (st_reg.mode == FSKM_LOOP && !ORIG_ANS);
  assign IRQ = |(st_reg.status & st_reg.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Qualified carrier: level held above through the count
  sequence s_cd_counted;
    above && st_reg.cd_cnt >= st_reg.delay && st_reg.mode != FSKM_PWRDN;
  endsequence

  sequence s_cd_low;
    !CARRIER_FOUND_N;
  endsequence

  a_pd_entry: assert property (@(posedge CORE_CLK) disable iff (RST)
    (LOOPBACK_SEL && TX_SQUELCH) |=> (POWER_DOWN && !TX_DRIVER_EN ##1 DAC_CODE == `FSKM_DAC_MID))
    else $error("power-down not entered");

  a_mode_select: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!LOOPBACK_SEL && ORIG_ANS) |=> (st_reg.mode == FSKM_ORIG && !LOOPBACK_EN && RX_BAND_HIGH))
    else $error("originate mode not set");

  a_squelch_mid: assert property (@(posedge CORE_CLK) disable iff (RST)
    TX_SQUELCH |=> (DAC_CODE == `FSKM_DAC_MID && !TX_DRIVER_EN))
    else $error("squelch did not silence output");

  a_phase_step: assert property (@(posedge CORE_CLK) disable iff (RST)
    tone_tick |=> st_reg.phase == $past(st_reg.phase) + 4'h1)
    else $error("phase did not step");

  a_phase_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!tone_tick && $changed(TXD)) |=> $stable(st_reg.phase))
    else $error("phase moved on data change");

  a_dac_follow: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!TX_SQUELCH && run) |=> DAC_CODE == $past(rom_data))
    else $error("dac not from sine table");

  a_band_answer: assert property (@(posedge CORE_CLK) disable iff (RST)
    (st_reg.mode == FSKM_ANS) |-> !RX_BAND_HIGH)
    else $error("answer band wrong");

  a_cd_qualify: assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(CARRIER_FOUND_N) |-> $past(above) && $past(st_reg.cd_cnt) >= $past(st_reg.delay))
    else $error("carrier found early");

  a_cd_assert: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_cd_counted |=> s_cd_low)
    else $error("carrier found missing");

  a_rx_decide: assert property (@(posedge CORE_CLK) disable iff (RST)
    (run && RX_MARK_ENERGY > RX_SPACE_ENERGY) |=> RX_DATA)
    else $error("mark not decided");

  a_tone_select: assert property (@(posedge CORE_CLK) disable iff (RST)
    (ORIG_ANS && TXD) |-> divisor == DIV_ORIG_MARK)
    else $error("wrong divisor");

  a_status_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
    (|events) |=> (st_reg.status & $past(events)) == $past(events))
    else $error("event lost");

  // Status read strobe
  sequence s_status_read;
    RD && ADDR == `FSKM_ADDR_STATUS;
  endsequence

  // Read clears status; events of the same cycle survive
  a_status_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_status_read |=> st_reg.status == $past(events))
    else $error("status not cleared by read");

  // Read data stand one cycle only
  a_rdata_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
    !RD |=> RDATA == '0)
    else $error("read data not cleared");

  // Threshold read returns the register
  a_rdata_thresh: assert property (@(posedge CORE_CLK) disable iff (RST)
    (RD && ADDR == `FSKM_ADDR_THRESH) |=> RDATA == $past(st_reg.thresh))
    else $error("threshold read wrong");

  // Carrier released one cycle after level falls
  a_cd_drop: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!above && !CARRIER_FOUND_N) |=> CARRIER_FOUND_N)
    else $error("carrier found held");

  // Loopback listens in its own band
  a_loop_band: assert property (@(posedge CORE_CLK) disable iff (RST)
    (st_reg.mode == FSKM_LOOP) |-> (LOOPBACK_EN && RX_BAND_HIGH == !ORIG_ANS))
    else $error("loopback band wrong");

  // Answer mode from host pins
  a_mode_answer: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!LOOPBACK_SEL && !ORIG_ANS) |=> (st_reg.mode == FSKM_ANS && !POWER_DOWN && !RX_BAND_HIGH))
    else $error("answer mode not set");

  // Driver on when neither squelched nor powered down
  a_drv_on: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!TX_SQUELCH && run) |=> TX_DRIVER_EN)
    else $error("driver not enabled");

  // Synthesizer frozen while powered down
  a_synth_halt: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!run && !tone_tick) |=> $stable(st_reg.phase))
    else $error("phase moved in power-down");

  // Receive bit held through power-down
  a_rx_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
    (st_reg.mode == FSKM_PWRDN) |=> $stable(RX_DATA))
    else $error("receive bit moved in power-down");

  // Answer space tone picks its divisor
  a_tone_answer: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!ORIG_ANS && !TXD) |-> divisor == DIV_ANS_SPACE)
    else $error("wrong answer divisor");

endmodule // fskm_core

//--- tb/fskm_line_model.sv
// Line-side model: receive level and mark/space detector energies toward the core
`timescale 1ns/1ps
module fskm_line_model (
  // Far-end tone control
  input wire logic carrier_on,
  input wire logic send_mark,
  // Measurements toward the core
  output logic [7:0] rx_level,
  output logic [7:0] mark_energy,
  output logic [7:0] space_energy
);
  // Levels sit one step beside the default threshold and beside equal energies
  always_comb begin
    rx_level = carrier_on ? 8'h41 : 8'h40;
    mark_energy = send_mark ? 8'h30 : 8'h2F;
    space_energy = 8'h30;
  end
endmodule // fskm_line_model

//--- tb/test_fsk_modem_synth_and_mode_control.sv
// Self-checking bench of the FSK modem core
`timescale 1ns/1ps
`include "fskm_defs.svh"
module test_fsk_modem_synth_and_mode_control import fskm_pkg::*;;
  // Shrunk divisors and tick so a run stays short
  localparam int DIVS [4] = '{8, 10, 12, 14};
  // Pin table {orig_ans, loopback, squelch, mode, pd, lb_en, band, drv}
  localparam logic [8:0] MODES [6] = '{9'b100010011, 9'b000100001, 9'b110110101,
                                       9'b010110111, 9'b101010010, 9'b011001000};
  logic core_clk, rst, txd, orig_ans, loopback_sel, tx_squelch, wr, rd;
  logic drv_en, band_high, lb_en, pwr_dn, cf_n, rx_data, irq, carrier_on, send_mark;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, dac_code, rx_level, mark_e, space_e, v, p0, mn, mx;
  int n_mismatch, checks_done;

  ////////////////////////////////////////////////////////////////////////////
  // Core and line model
  fskm_core #(.DIV_ORIG_MARK(13'd8), .DIV_ORIG_SPACE(13'd10), .DIV_ANS_MARK(13'd12),
    .DIV_ANS_SPACE(13'd14), .TICK_DIV(17'd10)) dut_u (.CORE_CLK(core_clk), .RST(rst),
    .TXD(txd), .ORIG_ANS(orig_ans), .LOOPBACK_SEL(loopback_sel), .TX_SQUELCH(tx_squelch),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_LEVEL(rx_level),
    .RX_MARK_ENERGY(mark_e), .RX_SPACE_ENERGY(space_e), .DAC_CODE(dac_code),
    .TX_DRIVER_EN(drv_en), .RX_BAND_HIGH(band_high), .LOOPBACK_EN(lb_en),
    .POWER_DOWN(pwr_dn), .CARRIER_FOUND_N(cf_n), .RX_DATA(rx_data), .IRQ(irq));
  fskm_line_model line_u (.carrier_on(carrier_on), .send_mark(send_mark),
    .rx_level(rx_level), .mark_energy(mark_e), .space_energy(space_e));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic set_pins(input logic oa, input logic lb, input logic sq, input logic tx);
    @(posedge core_clk);
    orig_ans <= oa;
    loopback_sel <= lb;
    tx_squelch <= sq;
    txd <= tx;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk("reset_outputs", 8'h0C, {1'b0, lb_en, band_high, rx_data, pwr_dn, cf_n, irq, drv_en});
    chk("reset_dac", `FSKM_DAC_MID, dac_code);
    chk("reset_rdata", 8'h00, rdata);
  endtask
  task automatic t_rerst;
    reg_wr(`FSKM_ADDR_DELAY, 8'h07);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1 t_reset();
    reg_rd(`FSKM_ADDR_DELAY, v);
    chk("delay_rerst", `FSKM_DELAY_RST, v);
  endtask
  task automatic t_regs;
    reg_rd(`FSKM_ADDR_MASK, v);
    chk("mask_reset", 8'h00, v);
    reg_rd(`FSKM_ADDR_THRESH, v);
    chk("thresh_reset", `FSKM_THRESH_RST, v);
    reg_rd(`FSKM_ADDR_DELAY, v);
    chk("delay_reset", `FSKM_DELAY_RST, v);
    @(posedge core_clk);
    #1 chk("rdata_after", 8'h00, rdata);
    reg_wr(4'h9, 8'h5A);
    reg_rd(4'h9, v);
    chk("unmapped_rd", 8'h00, v);
    reg_wr(`FSKM_ADDR_THRESH, 8'h55);
    reg_rd(`FSKM_ADDR_THRESH, v);
    chk("thresh_rw", 8'h55, v);
    reg_wr(`FSKM_ADDR_THRESH, `FSKM_THRESH_RST);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 6; i++) begin
      set_pins(MODES[i][8], MODES[i][7], MODES[i][6], 1'b1);
      chk("mode_pins", {4'h0, MODES[i][3:0]}, {4'h0, pwr_dn, lb_en, band_high, drv_en});
      if (!MODES[i][0]) chk("squelch_dac", `FSKM_DAC_MID, dac_code);
      reg_rd(`FSKM_ADDR_STATE, v);
      chk("mode_code", {6'h0, MODES[i][5:4]}, v & 8'h03);
    end
  endtask
  task automatic t_tones;
    for (int i = 0; i < 4; i++) begin
      set_pins(i < 2, 1'b0, 1'b0, !i[0]);
      repeat (40) @(posedge core_clk);
      reg_rd(`FSKM_ADDR_STATE, p0);
      repeat (DIVS[i] - 2) @(posedge core_clk);
      reg_rd(`FSKM_ADDR_STATE, v);
      chk("phase_step", {p0[7:4] + 4'h1, 4'h0}, v & 8'hF0);
      repeat (16 * DIVS[i] - 2) @(posedge core_clk);
      reg_rd(`FSKM_ADDR_STATE, p0);
      chk("phase_wrap", v & 8'hF0, p0 & 8'hF0);
    end
  endtask
  task automatic t_switch;
    set_pins(1'b1, 1'b0, 1'b0, 1'b1);
    mn = 8'hFF;
    mx = 8'h00;
    for (int k = 0; k < 128; k++) begin
      @(posedge core_clk);
      #1;
      if (dac_code < mn) mn = dac_code;
      if (dac_code > mx) mx = dac_code;
    end
    chk("dac_swing", 8'h01, 8'((mx > `FSKM_DAC_MID) && (mn < `FSKM_DAC_MID)));
    reg_rd(`FSKM_ADDR_STATE, p0);
    @(posedge core_clk);
    txd <= 1'b0;
    repeat (5) @(posedge core_clk);
    reg_rd(`FSKM_ADDR_STATE, v);
    chk("phase_keep", {p0[7:4] + 4'h1, 4'h0}, v & 8'hF0);
  endtask
  task automatic t_carrier;
    reg_wr(`FSKM_ADDR_DELAY, 8'h03);
    reg_wr(`FSKM_ADDR_MASK, 8'h03);
    reg_rd(`FSKM_ADDR_STATUS, v);
    @(posedge core_clk);
    carrier_on <= 1'b1;
    repeat (18) @(posedge core_clk);
    #1 chk("cf_early", 8'h01, 8'(cf_n));
    for (int k = 0; k < 40 && cf_n !== 1'b0; k++) begin
      @(posedge core_clk);
      #1;
    end
    #1 chk("cf_found", 8'h00, 8'(cf_n));
    chk("irq_on", 8'h01, 8'(irq));
    reg_rd(`FSKM_ADDR_STATUS, v);
    chk("status_on", 8'h01, v & 8'h03);
    @(posedge core_clk);
    #1 chk("irq_clear", 8'h00, 8'(irq));
    @(posedge core_clk);
    carrier_on <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk("cf_lost", 8'h01, {7'h0, cf_n});
    chk("irq_lost", 8'h01, 8'(irq));
    reg_wr(`FSKM_ADDR_MASK, 8'h00);
    @(posedge core_clk);
    #1 chk("irq_masked", 8'h00, 8'(irq));
    reg_rd(`FSKM_ADDR_STATUS, v);
    chk("status_off", 8'h02, v & 8'h03);
  endtask
  task automatic t_rx;
    @(posedge core_clk);
    send_mark <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk("rx_mark", 8'h01, 8'(rx_data));
    @(posedge core_clk);
    send_mark <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk("rx_space", 8'h00, 8'(rx_data));
    reg_rd(`FSKM_ADDR_STATUS, v);
    chk("status_rx", 8'h04, v & 8'h04);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Watchdog against a hang
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {txd, orig_ans, loopback_sel, tx_squelch, wr, rd, carrier_on, send_mark} = 8'h00;
    addr = 4'h0;
    wdata = 8'h00;
    n_mismatch = 0;
    checks_done = 0;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1 t_reset();
    t_regs();
    t_modes();
    t_tones();
    t_switch();
    t_carrier();
    t_rx();
    t_rerst();
    print_verdict();
  end
endmodule // test_fsk_modem_synth_and_mode_control
